// ==== verilog/bca_unit.sv ====
/*
 Convert/add datapath: decimal to binary, binary to decimal and
 signed 16/32-bit addition, run from an Avalon-MM register file.
 Assumes one 40 MHz clock, synchronous reset and a master that
 holds its request until waitrequest is seen low.
*/
// Operation
// - four-bit destination keeps lowest decimal digit
// - decimal source converted to binary destination
// - accept 0..9999 or 0..99999999 sources
// - bad digit sets both error flags, code
// - error flag, latched error flag, error code
// - second index register forbids 32-bit conversion
// - add stores sum of both sources
// - top bit is sign, signed arithmetic
// - 32-bit operand is low/high register pair
// - zero flag when sum is zero
// - 16-bit borrow below -32768
// - 16-bit carry above 32767
// - 32-bit borrow below -2147483648
// - 32-bit carry above 2147483647
// - second index register forbids 32-bit add
// - binary to decimal overrange raises error
`include "bca_defines.svh"
module bca_unit
   import bca_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Avalon-MM slave
   input wire bca_avm_req_t avm_in,
   output logic [31:0] avm_readdata_out,
   output logic avm_waitrequest_out,
   // Interrupt and flag pins
   output logic irq_out,
   output logic zero_result_flag_out,
   output logic borrow_result_flag_out,
   output logic carry_result_flag_out,
   output logic execution_error_flag_out
);
   // ==========================================================
   // Helper functions
   // True when every nibble is a decimal digit
   function automatic logic dec_valid(input logic [31:0] v);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 8; i++) begin
         if (v[4*i +: 4] > 4'h9) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   // Packed decimal to binary, most significant digit first
   function automatic logic [31:0] dec_to_bin(input logic [31:0] v);
      logic [31:0] acc;
      acc = 32'h0;
      for (int i = 7; i >= 0; i--) begin
         acc = acc * `BCA_DEC_TEN + {28'h0, v[4*i +: 4]};
      end
      return acc;
   endfunction

   // Binary to packed decimal by shift-and-add-three
   function automatic logic [31:0] bin_to_dec(input logic [31:0] v);
      logic [63:0] sh;
      sh = {32'h0, v};
      for (int i = 0; i < 32; i++) begin
         for (int j = 0; j < 8; j++) begin
            if (sh[32+4*j +: 4] >= `BCA_DD_LIMIT) begin
               sh[32+4*j +: 4] = sh[32+4*j +: 4] + `BCA_DD_ADJ;
            end
         end
         sh = {sh[62:0], 1'b0};
      end
      return sh[63:32];
   endfunction

   // ==========================================================
   // Register state
   bca_state_t state;         // Sequencer state
   logic [2:0] op_sel;        // Selected operation
   logic idx_f;               // Operands use second index register
   logic nib_dest;            // Destination is a four-bit group
   logic [15:0] src_a_lo;     // Source A low word
   logic [15:0] src_a_hi;     // Source A high word
   logic [15:0] src_b_lo;     // Source B low word
   logic [15:0] src_b_hi;     // Source B high word
   logic [15:0] res_lo;       // Destination low word
   logic [15:0] res_hi;       // Destination high word
   logic [15:0] error_code_word;
   logic [7:0] step_count;    // Program steps of last operation
   logic [2:0] irq_stat;      // Sticky events
   logic [2:0] irq_en;        // Event enables
   logic execution_error_latched_flag;
   logic bus_acc;             // Access completes this cycle
   logic bus_wr;              // Completed write
   logic start_req;           // Start written this cycle
   logic latch_clr;           // Software clears latched error

   // ==========================================================
   // Bus handshake: one wait cycle on every access
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         avm_waitrequest_out <= 1'b1;
      end else begin
         avm_waitrequest_out <=
            !((avm_in.read || avm_in.write) && avm_waitrequest_out);
      end
   end
   assign bus_acc = (avm_in.read || avm_in.write) && !avm_waitrequest_out;
   assign bus_wr = bus_acc && avm_in.write;
   assign start_req = bus_wr && (avm_in.address == `BCA_OFS_CTRL) &&
                      avm_in.writedata[`BCA_CTRL_START];
   assign latch_clr = bus_wr && (avm_in.address == `BCA_OFS_FLAGS) &&
                      avm_in.writedata[`BCA_FLG_LATCH];

   // ==========================================================
   // Operand and control registers, held while busy
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         op_sel <= 3'h0;
         idx_f <= 1'b0;
         nib_dest <= 1'b0;
         src_a_lo <= 16'h0;
         src_a_hi <= 16'h0;
         src_b_lo <= 16'h0;
         src_b_hi <= 16'h0;
      end else if (bus_wr && state == BCA_IDLE) begin
         case (avm_in.address)
            `BCA_OFS_CTRL: begin
               op_sel <= avm_in.writedata[`BCA_CTRL_OP_MSB:0];
               idx_f <= avm_in.writedata[`BCA_CTRL_IDXF];
               nib_dest <= avm_in.writedata[`BCA_CTRL_NIB];
            end
            `BCA_OFS_SRC_A_LO: src_a_lo <= avm_in.writedata[15:0];
            `BCA_OFS_SRC_A_HI: src_a_hi <= avm_in.writedata[15:0];
            `BCA_OFS_SRC_B_LO: src_b_lo <= avm_in.writedata[15:0];
            `BCA_OFS_SRC_B_HI: src_b_hi <= avm_in.writedata[15:0];
            default: begin
               // Other offsets hold no operand
            end
         endcase
      end
   end

   // Interrupt enable register
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         irq_en <= 3'h0;
      end else if (bus_wr && avm_in.address == `BCA_OFS_IRQ_EN) begin
         irq_en <= avm_in.writedata[2:0];
      end
   end

   // ==========================================================
   // Sequencer: start in idle, one execute cycle
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         state <= BCA_IDLE;
      end else begin
         case (state)
            BCA_IDLE: if (start_req) state <= BCA_EXEC;
            BCA_EXEC: state <= BCA_IDLE;
            default: state <= BCA_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Datapath, evaluated in the execute cycle
   logic [31:0] a32;          // Source A as one word
   logic [31:0] b32;          // Source B as one word
   logic [32:0] sum33;        // True 32-bit sum
   logic [16:0] sum17;        // True 16-bit sum
   logic wide;                // Operation is 32-bit
   logic refused;             // Form not allowed with index F
   logic op_err;              // Operation error
   logic [31:0] next_res;     // Destination value
   logic next_zero;
   logic next_borrow;
   logic next_carry;
   logic [7:0] next_steps;
   logic [31:0] dec_src;      // Decimal source, width masked
   logic [31:0] dec_out;      // Packed decimal of the binary source

   assign a32 = {src_a_hi, src_a_lo};
   assign b32 = {src_b_hi, src_b_lo};
   // Sign extension makes the sums exact
   assign sum33 = {a32[31], a32} + {b32[31], b32};
   assign sum17 = {src_a_lo[15], src_a_lo} + {src_b_lo[15], src_b_lo};
   assign wide = (op_sel == BCA_OP_DEC2BIN32) || (op_sel == BCA_OP_ADD32)
                 || (op_sel == BCA_OP_BIN2DEC32);
   assign refused = idx_f && wide;

   always_comb begin
      next_res = {res_hi, res_lo};
      next_zero = zero_result_flag_out;
      next_borrow = borrow_result_flag_out;
      next_carry = carry_result_flag_out;
      next_steps = wide ? `BCA_STEPS_CONV32 : `BCA_STEPS_CONV16;
      op_err = 1'b0;
      dec_src = wide ? a32 : {16'h0, src_a_lo};
      dec_out = bin_to_dec(dec_src);
      case (op_sel)
         BCA_OP_DEC2BIN, BCA_OP_DEC2BIN32: begin
            // Four digits fit 16 bits, so range is inherent
            if (!dec_valid(dec_src)) begin
               op_err = 1'b1;
            end else begin
               next_res = dec_to_bin(dec_src);
            end
         end
         BCA_OP_ADD: begin
            next_res = {{16{sum17[15]}}, sum17[15:0]};
            next_zero = (sum17 == 17'h0);
            next_borrow = sum17[16] && !sum17[15];
            next_carry = !sum17[16] && sum17[15];
            next_steps = `BCA_STEPS_ADD16;
         end
         BCA_OP_ADD32: begin
            next_res = sum33[31:0];
            next_zero = (sum33 == 33'h0);
            next_borrow = sum33[32] && !sum33[31];
            next_carry = !sum33[32] && sum33[31];
            next_steps = `BCA_STEPS_ADD32;
         end
         BCA_OP_BIN2DEC, BCA_OP_BIN2DEC32: begin
            // Negative sources are out of range as unsigned magnitude
            if (dec_src > (wide ? `BCA_MAX_DEC32 : `BCA_MAX_DEC16)) begin
               op_err = 1'b1;
            end else if (nib_dest) begin
               next_res = {28'h0, dec_out[3:0]};
            end else begin
               next_res = dec_out;
            end
         end
         default: begin
            op_err = 1'b1;
         end
      endcase
   end

   // ==========================================================
   // Result and flag registers
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         res_lo <= 16'h0;
         res_hi <= 16'h0;
         zero_result_flag_out <= 1'b0;
         borrow_result_flag_out <= 1'b0;
         carry_result_flag_out <= 1'b0;
         step_count <= 8'h0;
      end else if (state == BCA_EXEC && !refused && !op_err) begin
         res_lo <= next_res[15:0];
         res_hi <= next_res[31:16];
         zero_result_flag_out <= next_zero;
         borrow_result_flag_out <= next_borrow;
         carry_result_flag_out <= next_carry;
         step_count <= next_steps;
      end
   end

   // Error flags: plain flag follows each run not refused, latched one sticks
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         execution_error_flag_out <= 1'b0;
         execution_error_latched_flag <= 1'b0;
         error_code_word <= 16'h0;
      end else begin
         if (state == BCA_EXEC && !refused) begin
            execution_error_flag_out <= op_err;
         end
         // Set wins over a same-cycle software clear
         if (state == BCA_EXEC && !refused && op_err) begin
            execution_error_latched_flag <= 1'b1;
            error_code_word <= `BCA_ERR_RANGE;
         end else if (latch_clr) begin
            execution_error_latched_flag <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Interrupt status: sticky, write-one-to-clear, set wins
   logic [2:0] ev_set;
   assign ev_set = (state == BCA_EXEC) ?
                   {refused, !refused && op_err, !refused} : 3'h0;
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         irq_stat <= 3'h0;
      end else begin
         irq_stat <= ev_set |
            (irq_stat & ~((bus_wr && avm_in.address == `BCA_OFS_IRQ_CLR) ?
                          avm_in.writedata[2:0] : 3'h0));
      end
   end

   // Level interrupt, registered from status and enable
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |((irq_stat | ev_set) & irq_en);
      end
   end

   // ==========================================================
   // Read data, loaded in the wait cycle so it stands at the ack
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         avm_readdata_out <= 32'h0;
      end else if (avm_in.read && avm_waitrequest_out) begin
         case (avm_in.address)
            `BCA_OFS_CTRL: avm_readdata_out <=
               {22'h0, state == BCA_EXEC, 3'h0, nib_dest, idx_f,
                1'b0, op_sel};
            `BCA_OFS_SRC_A_LO: avm_readdata_out <= {16'h0, src_a_lo};
            `BCA_OFS_SRC_A_HI: avm_readdata_out <= {16'h0, src_a_hi};
            `BCA_OFS_SRC_B_LO: avm_readdata_out <= {16'h0, src_b_lo};
            `BCA_OFS_SRC_B_HI: avm_readdata_out <= {16'h0, src_b_hi};
            `BCA_OFS_RES_LO: avm_readdata_out <= {16'h0, res_lo};
            `BCA_OFS_RES_HI: avm_readdata_out <= {16'h0, res_hi};
            `BCA_OFS_FLAGS: avm_readdata_out <=
               {27'h0, execution_error_latched_flag,
                execution_error_flag_out, carry_result_flag_out,
                borrow_result_flag_out, zero_result_flag_out};
            `BCA_OFS_ERR_CODE: avm_readdata_out <= {16'h0, error_code_word};
            `BCA_OFS_STEPS: avm_readdata_out <= {24'h0, step_count};
            `BCA_OFS_IRQ_STAT: avm_readdata_out <= {29'h0, irq_stat};
            `BCA_OFS_IRQ_EN: avm_readdata_out <= {29'h0, irq_en};
            default: avm_readdata_out <= 32'h0;
         endcase
      end
   end

   // ==========================================================
   // Checks
   bad_digit_err_a: assert property (@(posedge ref_clk_in)
      disable iff (rst_in)
      (state == BCA_EXEC && !refused && !wide && op_sel == BCA_OP_DEC2BIN
       && !dec_valid({16'h0, src_a_lo}))
      |=> execution_error_flag_out && execution_error_latched_flag
          && error_code_word == `BCA_ERR_RANGE)
      else $error("bad digit did not raise error");
   dec_value_ok_a: assert property (@(posedge ref_clk_in)
      disable iff (rst_in)
      (state == BCA_EXEC && op_sel == BCA_OP_DEC2BIN && src_a_lo == 16'h9999)
      |=> {res_hi, res_lo} == `BCA_MAX_DEC16)
      else $error("decimal 9999 not converted");
   latch_holds_a: assert property (@(posedge ref_clk_in)
      disable iff (rst_in)
      execution_error_latched_flag && !latch_clr
      |=> execution_error_latched_flag)
      else $error("latched error dropped without clear");
   wide_refused_a: assert property (@(posedge ref_clk_in)
      disable iff (rst_in)
      (state == BCA_EXEC && idx_f && wide)
      |=> $stable({res_hi, res_lo}) && irq_stat[`BCA_EV_REFUSE])
      else $error("32-bit form ran with index F");
   add16_flags_a: assert property (@(posedge ref_clk_in)
      disable iff (rst_in)
      (state == BCA_EXEC && op_sel == BCA_OP_ADD && !src_a_lo[15]
       && !src_b_lo[15] && $signed(sum17) > 17'sh07FFF)
      |=> carry_result_flag_out && !borrow_result_flag_out)
      else $error("16-bit carry missed");
   add16_borrow_a: assert property (@(posedge ref_clk_in)
      disable iff (rst_in)
      (state == BCA_EXEC && op_sel == BCA_OP_ADD
       && $signed(sum17) < -17'sh08000)
      |=> borrow_result_flag_out && !carry_result_flag_out)
      else $error("16-bit borrow missed");
   add32_wrap_a: assert property (@(posedge ref_clk_in)
      disable iff (rst_in)
      (state == BCA_EXEC && op_sel == BCA_OP_ADD32 && !idx_f)
      |=> {res_hi, res_lo} == $past(a32) + $past(b32)
          && zero_result_flag_out == ($past(sum33) == 33'h0))
      else $error("32-bit sum not stored");
   nibble_dest_a: assert property (@(posedge ref_clk_in)
      disable iff (rst_in)
      (state == BCA_EXEC && op_sel == BCA_OP_BIN2DEC && nib_dest
       && !op_err)
      |=> res_hi == 16'h0 && res_lo[15:4] == 12'h0)
      else $error("four-bit group got more than one digit");
   overrange_a: assert property (@(posedge ref_clk_in)
      disable iff (rst_in)
      (state == BCA_EXEC && op_sel == BCA_OP_BIN2DEC
       && {16'h0, src_a_lo} > `BCA_MAX_DEC16)
      |=> execution_error_flag_out ##1 execution_error_latched_flag)
      else $error("binary over 9999 not flagged");
endmodule

// ==== pkg/bca_defines.svh ====
/*
 Register map, field positions, codes and step counts of the
 convert/add unit. Assumes it is included by bare name only.
*/
`ifndef BCA_DEFINES_SVH
`define BCA_DEFINES_SVH
// ==========================================================
// Register byte offsets
`define BCA_OFS_CTRL 8'h00
`define BCA_OFS_SRC_A_LO 8'h04
`define BCA_OFS_SRC_A_HI 8'h08
`define BCA_OFS_SRC_B_LO 8'h0C
`define BCA_OFS_SRC_B_HI 8'h10
`define BCA_OFS_RES_LO 8'h14
`define BCA_OFS_RES_HI 8'h18
`define BCA_OFS_FLAGS 8'h1C
`define BCA_OFS_ERR_CODE 8'h20
`define BCA_OFS_STEPS 8'h24
`define BCA_OFS_IRQ_STAT 8'h28
`define BCA_OFS_IRQ_CLR 8'h2C
`define BCA_OFS_IRQ_EN 8'h30
// ==========================================================
// Control fields
`define BCA_CTRL_OP_MSB 2
`define BCA_CTRL_IDXF 4
`define BCA_CTRL_NIB 5
`define BCA_CTRL_START 8
`define BCA_CTRL_BUSY 9
// ==========================================================
// Flag and event bit positions
`define BCA_FLG_ZERO 0
`define BCA_FLG_BORROW 1
`define BCA_FLG_CARRY 2
`define BCA_FLG_ERR 3
`define BCA_FLG_LATCH 4
`define BCA_EV_DONE 0
`define BCA_EV_ERR 1
`define BCA_EV_REFUSE 2
// ==========================================================
// Codes, limits and program step counts
`define BCA_ERR_RANGE 16'h0E18
`define BCA_MAX_DEC16 32'h0000270F
`define BCA_MAX_DEC32 32'h05F5E0FF
`define BCA_STEPS_CONV16 8'h05
`define BCA_STEPS_CONV32 8'h09
`define BCA_STEPS_ADD16 8'h07
`define BCA_STEPS_ADD32 8'h0D
`define BCA_DD_LIMIT 4'h5
`define BCA_DD_ADJ 4'h3
`define BCA_DEC_TEN 32'h0000000A
`endif

// ==== pkg/bca_pkg.sv ====
/*
 Types of the convert/add unit: operations, states, bus carrier.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package bca_pkg;
   // ==========================================================
   // Operation codes as written into the control register
   typedef enum logic [2:0] {
      BCA_OP_DEC2BIN = 3'h0,
      BCA_OP_DEC2BIN32 = 3'h1,
      BCA_OP_ADD = 3'h2,
      BCA_OP_ADD32 = 3'h3,
      BCA_OP_BIN2DEC = 3'h4,
      BCA_OP_BIN2DEC32 = 3'h5
   } bca_op_t;
   // Sequencer states
   typedef enum logic {BCA_IDLE, BCA_EXEC} bca_state_t;
   // Avalon-MM request from the master
   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
   } bca_avm_req_t;
endpackage

// ==== tb/bca_seq_model.sv ====
/*
 Sequencer model: the bus master that feeds the convert/add unit.
 Assumes the unit answers with waitrequest low for one cycle.
*/
// ==========================================================
// Master side of the register bus
module bca_seq_model
   import bca_pkg::*;
(
   // Clock
   input wire logic ref_clk_in,
   // Answer from the unit
   input wire logic avm_waitrequest_in,
   input wire logic [31:0] avm_readdata_in,
   // Request to the unit
   output bca_avm_req_t avm_req_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle bus at time zero
   initial begin
      avm_req_out = '0;
   end
   // One access: raise, hold until waitrequest low, release
   task automatic access(input logic is_wr, input logic [7:0] addr,
         input logic [31:0] data, output logic [31:0] rdata);
      @(posedge ref_clk_in);
      avm_req_out <= '{!is_wr, is_wr, addr, data};
      // No cycle count assumed; the bench watchdog ends a dead wait
      do begin
         @(posedge ref_clk_in);
      end while (avm_waitrequest_in !== 1'b0);
      rdata = avm_readdata_in;
      // Released lines show the inverse, never the stale value
      avm_req_out <= '{1'b0, 1'b0, ~addr, ~data};
   endtask
endmodule

// ==== tb/bca_unit_bench.sv ====
/*
 Self-checking bench of the convert/add unit: register accesses
 and operation runs with expected values.
 Assumes the sequencer model in its own file and the unit's defines.
*/
`include "bca_defines.svh"
module bca_unit_bench import bca_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================================
   // Signals
   logic ref_clk_in; // 40 MHz
   logic rst_in; // Synchronous, high
   bca_avm_req_t avm_req;
   logic [31:0] rdata;
   logic waitreq, irq, zf, bf, cf, ef;
   int errors;
   int total_checks;
   // ==========================================================
   // Unit and master
   bca_unit DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .avm_in(avm_req), .avm_readdata_out(rdata),
      .avm_waitrequest_out(waitreq), .irq_out(irq),
      .zero_result_flag_out(zf), .borrow_result_flag_out(bf),
      .carry_result_flag_out(cf), .execution_error_flag_out(ef));
   bca_seq_model seq (.ref_clk_in(ref_clk_in),
      .avm_waitrequest_in(waitreq), .avm_readdata_in(rdata),
      .avm_req_out(avm_req));
   // Clock
   initial begin
      ref_clk_in = 1'b0;
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end
   // ==========================================================
   // Helpers
   // Compare and count
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
         input string what);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR at %0t: %s got %h expected %h", $time, what,
            got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] unused;
      seq.access(1'b1, a, d, unused);
   endtask
   // Registers are 16 bits wide; upper half not judged
   task automatic chk(input logic [7:0] a, input logic [15:0] exp);
      logic [31:0] v;
      seq.access(1'b0, a, 32'h0, v);
      cmp({16'h0, v[15:0]}, {16'h0, exp}, $sformatf("read %h", a));
   endtask
   // Load operands, start, and wait out the run
   task automatic run(input logic [2:0] op, input logic [1:0] md,
         input logic [31:0] a, input logic [31:0] b);
      wr(`BCA_OFS_SRC_A_LO, {16'h0, a[15:0]});
      wr(`BCA_OFS_SRC_A_HI, {16'h0, a[31:16]});
      wr(`BCA_OFS_SRC_B_LO, {16'h0, b[15:0]});
      wr(`BCA_OFS_SRC_B_HI, {16'h0, b[31:16]});
      wr(`BCA_OFS_CTRL, {23'h0, 1'b1, 2'h0, md, 1'h0, op});
      repeat (3) @(posedge ref_clk_in);
   endtask
   // Result pair, flag register and flag pins
   task automatic res(input logic [31:0] r, input logic [4:0] f);
      chk(`BCA_OFS_RES_LO, r[15:0]);
      chk(`BCA_OFS_RES_HI, r[31:16]);
      chk(`BCA_OFS_FLAGS, {11'h0, f});
      cmp({28'h0, ef, cf, bf, zf}, {28'h0, f[3:0]}, "flag pins");
   endtask
   // Verdict, reached from the tests and the watchdog alike
   task automatic stop_test();
      if (errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Watchdog, far beyond the fewer than 1000 cycles needed
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      errors++;
      stop_test();
   end
   // ==========================================================
   // Tests
   initial begin
      errors = 0;
      total_checks = 0;
      rst_in = 1'b1;
      repeat (12) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      res(32'h0, 5'h00);
      chk(`BCA_OFS_IRQ_STAT, 16'h0);
      // Decimal to binary, both widths
      run(BCA_OP_DEC2BIN, 2'h0, 32'h00001234, 32'h0);
      res(32'h000004D2, 5'h00);
      chk(`BCA_OFS_STEPS, 16'h5);
      run(BCA_OP_DEC2BIN, 2'h0, 32'hFFFF9999, 32'h0);
      res(32'h0000270F, 5'h00);
      run(BCA_OP_DEC2BIN32, 2'h0, 32'h99999999, 32'h0);
      res(32'h05F5E0FF, 5'h00);
      chk(`BCA_OFS_STEPS, 16'h9);
      // Bad digits: result kept, both error flags, code
      run(BCA_OP_DEC2BIN, 2'h0, 32'h000012A4, 32'h0);
      res(32'h05F5E0FF, 5'h18);
      chk(`BCA_OFS_ERR_CODE, 16'h0E18);
      run(BCA_OP_DEC2BIN32, 2'h0, 32'hB0000000, 32'h0);
      res(32'h05F5E0FF, 5'h18);
      // Good run clears the error flag, the latched one stays
      run(BCA_OP_DEC2BIN, 2'h0, 32'h00000012, 32'h0);
      res(32'h0000000C, 5'h10);
      wr(`BCA_OFS_FLAGS, 32'h10);
      chk(`BCA_OFS_FLAGS, 16'h0);
      // Second index register refuses 32-bit forms only
      wr(`BCA_OFS_IRQ_CLR, 32'h7);
      run(BCA_OP_DEC2BIN32, 2'h1, 32'h00000034, 32'h0);
      res(32'h0000000C, 5'h00);
      chk(`BCA_OFS_IRQ_STAT, 16'h4);
      run(BCA_OP_ADD32, 2'h1, 32'h1, 32'h1);
      res(32'h0000000C, 5'h00);
      chk(`BCA_OFS_IRQ_STAT, 16'h4);
      run(BCA_OP_DEC2BIN, 2'h1, 32'h00000034, 32'h0);
      res(32'h00000022, 5'h00);
      run(BCA_OP_ADD, 2'h1, 32'h2, 32'h3);
      res(32'h00000005, 5'h00);
      chk(`BCA_OFS_IRQ_STAT, 16'h5);
      // Binary to decimal, four-bit group, over range
      run(BCA_OP_BIN2DEC, 2'h0, 32'h0000270F, 32'h0);
      res(32'h00009999, 5'h00);
      run(BCA_OP_BIN2DEC, 2'h2, 32'h0000001E, 32'h0);
      res(32'h0, 5'h00);
      run(BCA_OP_BIN2DEC, 2'h2, 32'h0000004D, 32'h0);
      res(32'h00000007, 5'h00);
      run(BCA_OP_BIN2DEC, 2'h0, 32'h00002710, 32'h0);
      res(32'h00000007, 5'h18);
      run(BCA_OP_BIN2DEC32, 2'h0, 32'h05F5E0FF, 32'h0);
      res(32'h99999999, 5'h10);
      run(BCA_OP_BIN2DEC32, 2'h0, 32'h05F5E100, 32'h0);
      res(32'h99999999, 5'h18);
      run(3'h6, 2'h0, 32'h0, 32'h0);
      res(32'h99999999, 5'h18);
      run(3'h7, 2'h0, 32'h0, 32'h0);
      res(32'h99999999, 5'h18);
      wr(`BCA_OFS_FLAGS, 32'h10);
      // Signed addition, 16 bits, wrapped results
      run(BCA_OP_ADD, 2'h0, 32'h3, 32'hFFF7);
      res(32'hFFFFFFFA, 5'h00);
      chk(`BCA_OFS_STEPS, 16'h7);
      run(BCA_OP_ADD, 2'h0, 32'h7FFF, 32'h1);
      res(32'hFFFF8000, 5'h04);
      run(BCA_OP_ADD, 2'h0, 32'h8000, 32'hFFFF);
      res(32'h00007FFF, 5'h02);
      run(BCA_OP_ADD, 2'h0, 32'h7FFF, 32'h0);
      res(32'h00007FFF, 5'h00);
      run(BCA_OP_ADD, 2'h0, 32'h5, 32'hFFFB);
      res(32'h0, 5'h01);
      // Signed addition, 32 bits from register pairs
      run(BCA_OP_ADD32, 2'h0, 32'h0001FFFF, 32'h00010001);
      res(32'h00030000, 5'h00);
      chk(`BCA_OFS_STEPS, 16'hD);
      run(BCA_OP_ADD32, 2'h0, 32'h7FFFFFFF, 32'h1);
      res(32'h80000000, 5'h04);
      run(BCA_OP_ADD32, 2'h0, 32'h80000000, 32'hFFFFFFFF);
      res(32'h7FFFFFFF, 5'h02);
      run(BCA_OP_ADD32, 2'h0, 32'hFFFFFFFF, 32'h1);
      res(32'h0, 5'h01);
      // Interrupt: raise, clear, mask, error event
      wr(`BCA_OFS_IRQ_CLR, 32'h7);
      chk(`BCA_OFS_IRQ_STAT, 16'h0);
      wr(`BCA_OFS_IRQ_EN, 32'h1);
      run(BCA_OP_ADD, 2'h0, 32'h1, 32'h1);
      cmp({31'h0, irq}, 32'h1, "irq after done");
      chk(`BCA_OFS_IRQ_STAT, 16'h1);
      wr(`BCA_OFS_IRQ_CLR, 32'h1);
      repeat (2) @(posedge ref_clk_in);
      cmp({31'h0, irq}, 32'h0, "irq after clear");
      wr(`BCA_OFS_IRQ_EN, 32'h2);
      run(BCA_OP_ADD, 2'h0, 32'h1, 32'h1);
      cmp({31'h0, irq}, 32'h0, "irq masked");
      run(3'h6, 2'h0, 32'h0, 32'h0);
      cmp({31'h0, irq}, 32'h1, "irq on error");
      chk(`BCA_OFS_IRQ_STAT, 16'h3);
      // Control read back: last opcode, no index, no nibble, idle
      chk(`BCA_OFS_CTRL, 16'h0006);
      wr(`BCA_OFS_IRQ_CLR, 32'h7);
      repeat (2) @(posedge ref_clk_in);
      cmp({31'h0, irq}, 32'h0, "irq cleared");
      // Write-only and unmapped places
      chk(`BCA_OFS_IRQ_CLR, 16'h0);
      wr(8'h40, 32'h5A5A);
      chk(8'h40, 16'h0);
      chk(`BCA_OFS_IRQ_EN, 16'h2);
      stop_test();
   end
endmodule
